// ===== src/ibr_pkg.sv
// Package: register map, field layout, reset values and types for the bit-rate and own-address block
package ibr_pkg;

  // ****************************************************************
  // Register map (byte addresses, one word each)
  // ****************************************************************
  localparam logic [7:0] ADDR_TARGET_ID = 8'h00;
  localparam logic [7:0] ADDR_BIT_RATE = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int SCALE_MSB = 7;
  localparam int SCALE_LSB = 6;
  localparam int CODE_MSB = 5;
  localparam int CODE_LSB = 0;
  localparam int STAT_ADDRESSED_BIT = 0;
  localparam int STAT_SCL_BIT = 1;
  localparam logic [7:0] RST_TARGET_ID = 8'h00;
  localparam logic [7:0] RST_BIT_RATE = 8'h00;

  // Multiplier codes
  localparam logic [1:0] SCALE_X1 = 2'h0;
  localparam logic [1:0] SCALE_X2 = 2'h1;
  localparam logic [1:0] SCALE_X4 = 2'h2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    IBR_PH_LOW = 2'b00,
    IBR_PH_HIGH = 2'b01
  } ibr_phase_t;

endpackage

// ===== src/ibr_top.sv
// Bit-rate generator and own target address with an AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none

module ibr_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Byte engine side
  input wire logic scl_run,
  input wire logic addr_valid,
  input wire logic [6:0] call_addr,
  input wire logic target_clear,
  input wire logic sda_change_req,
  output logic scl_out,
  output logic sda_change_en,
  output logic addressed_as_target_flag
);
  import ibr_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0] target_id_register;
    logic [7:0] bit_rate_register;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    ibr_phase_t phase;
    logic [13:0] cnt;
    logic scl;
    logic [9:0] hold_cnt;
    logic hold_busy;
    logic sda_en;
    logic flag;
  } ibr_state_t;

  ibr_state_t cur_ff;
  ibr_state_t nxt_ff;

  logic [11:0] div_sel;
  logic [9:0] hold_sel;
  logic [13:0] period;
  logic [13:0] half;
  logic addr_phase;

  always_comb begin
    // Fixed rate table: serial clock divider per rate code
    case (cur_ff.bit_rate_register[CODE_MSB:CODE_LSB])
      6'h00: div_sel = 12'h014;
      6'h01: div_sel = 12'h016;
      6'h02: div_sel = 12'h018;
      6'h03: div_sel = 12'h01a;
      6'h04: div_sel = 12'h01c;
      6'h05: div_sel = 12'h01e;
      6'h06: div_sel = 12'h022;
      6'h07: div_sel = 12'h028;
      6'h08: div_sel = 12'h01c;
      6'h09: div_sel = 12'h020;
      6'h0a: div_sel = 12'h024;
      6'h0b: div_sel = 12'h028;
      6'h0c: div_sel = 12'h02c;
      6'h0d: div_sel = 12'h030;
      6'h0e: div_sel = 12'h038;
      6'h0f: div_sel = 12'h044;
      6'h10: div_sel = 12'h030;
      6'h11: div_sel = 12'h038;
      6'h12: div_sel = 12'h040;
      6'h13: div_sel = 12'h048;
      6'h14: div_sel = 12'h050;
      6'h15: div_sel = 12'h058;
      6'h16: div_sel = 12'h068;
      6'h17: div_sel = 12'h080;
      6'h18: div_sel = 12'h050;
      6'h19: div_sel = 12'h060;
      6'h1a: div_sel = 12'h070;
      6'h1b: div_sel = 12'h080;
      6'h1c: div_sel = 12'h090;
      6'h1d: div_sel = 12'h0a0;
      6'h1e: div_sel = 12'h0c0;
      6'h1f: div_sel = 12'h0f0;
      6'h20: div_sel = 12'h0a0;
      6'h21: div_sel = 12'h0c0;
      6'h22: div_sel = 12'h0e0;
      6'h23: div_sel = 12'h100;
      6'h24: div_sel = 12'h120;
      6'h25: div_sel = 12'h140;
      6'h26: div_sel = 12'h180;
      6'h27: div_sel = 12'h1e0;
      6'h28: div_sel = 12'h140;
      6'h29: div_sel = 12'h180;
      6'h2a: div_sel = 12'h1c0;
      6'h2b: div_sel = 12'h200;
      6'h2c: div_sel = 12'h240;
      6'h2d: div_sel = 12'h280;
      6'h2e: div_sel = 12'h300;
      6'h2f: div_sel = 12'h3c0;
      6'h30: div_sel = 12'h280;
      6'h31: div_sel = 12'h300;
      6'h32: div_sel = 12'h380;
      6'h33: div_sel = 12'h400;
      6'h34: div_sel = 12'h480;
      6'h35: div_sel = 12'h500;
      6'h36: div_sel = 12'h600;
      6'h37: div_sel = 12'h780;
      6'h38: div_sel = 12'h500;
      6'h39: div_sel = 12'h600;
      6'h3a: div_sel = 12'h700;
      6'h3b: div_sel = 12'h800;
      6'h3c: div_sel = 12'h900;
      6'h3d: div_sel = 12'ha00;
      6'h3e: div_sel = 12'hc00;
      6'h3f: div_sel = 12'hf00;
      default: div_sel = 12'h014;
    endcase
    // Hold values come in pairs of codes, so the lowest code bit is left out
    case (cur_ff.bit_rate_register[CODE_MSB:CODE_LSB + 1])
      5'h00: hold_sel = 10'h007;
      5'h01: hold_sel = 10'h008;
      5'h02: hold_sel = 10'h009;
      5'h03: hold_sel = 10'h00a;
      5'h04: hold_sel = 10'h007;
      5'h05: hold_sel = 10'h009;
      5'h06: hold_sel = 10'h00b;
      5'h07: hold_sel = 10'h00d;
      5'h08: hold_sel = 10'h009;
      5'h09: hold_sel = 10'h00d;
      5'h0a: hold_sel = 10'h011;
      5'h0b: hold_sel = 10'h015;
      5'h0c: hold_sel = 10'h009;
      5'h0d: hold_sel = 10'h011;
      5'h0e: hold_sel = 10'h019;
      5'h0f: hold_sel = 10'h021;
      5'h10: hold_sel = 10'h011;
      5'h11: hold_sel = 10'h021;
      5'h12: hold_sel = 10'h031;
      5'h13: hold_sel = 10'h041;
      5'h14: hold_sel = 10'h021;
      5'h15: hold_sel = 10'h041;
      5'h16: hold_sel = 10'h061;
      5'h17: hold_sel = 10'h081;
      5'h18: hold_sel = 10'h041;
      5'h19: hold_sel = 10'h081;
      5'h1a: hold_sel = 10'h0c1;
      5'h1b: hold_sel = 10'h101;
      5'h1c: hold_sel = 10'h081;
      5'h1d: hold_sel = 10'h101;
      5'h1e: hold_sel = 10'h181;
      5'h1f: hold_sel = 10'h201;
      default: hold_sel = 10'h007;
    endcase
    // Reserved factor code falls back to x1 so the divider never stalls
    case (cur_ff.bit_rate_register[SCALE_MSB:SCALE_LSB])
      SCALE_X2: period = {1'b0, div_sel, 1'b0};
      SCALE_X4: period = {div_sel, 2'b00};
      default: period = {2'b00, div_sel};
    endcase
    half = {1'b0, period[13:1]};
    addr_phase = hsel && hready && htrans[1];
  end

  always_comb begin
    nxt_ff = cur_ff;
    // ****************************************************************
    // Register slave: writes commit in the data phase
    // ****************************************************************
    nxt_ff.wr_pend = addr_phase && hwrite;
    nxt_ff.wr_addr = haddr[7:0];
    if (cur_ff.wr_pend) begin
      case (cur_ff.wr_addr)
        ADDR_TARGET_ID: nxt_ff.target_id_register = hwdata[7:0];
        ADDR_BIT_RATE: nxt_ff.bit_rate_register = hwdata[7:0];
        default: ;
      endcase
    end
    if (addr_phase && !hwrite) begin
      case (haddr[7:0])
        ADDR_TARGET_ID: nxt_ff.rdata = {24'h000000, cur_ff.target_id_register};
        ADDR_BIT_RATE: nxt_ff.rdata = {24'h000000, cur_ff.bit_rate_register};
        ADDR_STATUS: nxt_ff.rdata = {30'h0, cur_ff.scl, cur_ff.flag};
        default: nxt_ff.rdata = 32'h00000000;
      endcase
    end
    // ****************************************************************
    // Serial clock: high half then low half of rate_scale_factor*divider cycles
    // ****************************************************************
    if (!scl_run) begin
      nxt_ff.cnt = 14'h0000;
      nxt_ff.phase = IBR_PH_HIGH;
      nxt_ff.scl = 1'b1;
    end else begin
      case (cur_ff.phase)
        IBR_PH_HIGH: begin
          if (cur_ff.cnt + 14'h0001 >= period - half) begin
            nxt_ff.cnt = 14'h0000;
            nxt_ff.phase = IBR_PH_LOW;
            nxt_ff.scl = 1'b0;
          end else begin
            nxt_ff.cnt = cur_ff.cnt + 14'h0001;
          end
        end
        IBR_PH_LOW: begin
          if (cur_ff.cnt + 14'h0001 >= half) begin
            nxt_ff.cnt = 14'h0000;
            nxt_ff.phase = IBR_PH_HIGH;
            nxt_ff.scl = 1'b1;
          end else begin
            nxt_ff.cnt = cur_ff.cnt + 14'h0001;
          end
        end
        default: begin
          nxt_ff.cnt = 14'h0000;
          nxt_ff.phase = IBR_PH_HIGH;
        end
      endcase
    end
    // ****************************************************************
    // Data hold: a change is allowed hold cycles after scl falls
    // ****************************************************************
    nxt_ff.sda_en = 1'b0;
    if (cur_ff.scl && !nxt_ff.scl) begin
      nxt_ff.hold_busy = 1'b1;
      nxt_ff.hold_cnt = 10'h001;
    end else if (cur_ff.hold_busy) begin
      if (cur_ff.hold_cnt >= hold_sel) begin
        nxt_ff.hold_busy = 1'b0;
        nxt_ff.sda_en = sda_change_req;
      end else begin
        nxt_ff.hold_cnt = cur_ff.hold_cnt + 10'h001;
      end
    end
    // ****************************************************************
    // Address match; a match in the clearing cycle wins
    // ****************************************************************
    if (target_clear) begin
      nxt_ff.flag = 1'b0;
    end
    if (addr_valid && call_addr == cur_ff.target_id_register[7:1]) begin
      nxt_ff.flag = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_ff <= '{target_id_register: RST_TARGET_ID, bit_rate_register: RST_BIT_RATE, wr_pend: 1'b0,
                  wr_addr: 8'h00, rdata: 32'h00000000, phase: IBR_PH_HIGH, cnt: 14'h0000, scl: 1'b1,
                  hold_cnt: 10'h000, hold_busy: 1'b0, sda_en: 1'b0, flag: 1'b0};
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign hrdata = cur_ff.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign scl_out = cur_ff.scl;
  assign sda_change_en = cur_ff.sda_en;
  assign addressed_as_target_flag = cur_ff.flag;

endmodule

`default_nettype wire

// ===== tb/ibr_props.sv
// Port checks for the bit-rate and own-address block
`timescale 1ns/1ps
`default_nettype none
module ibr_props (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // Engine side
  input wire logic scl_run,
  input wire logic addr_valid,
  input wire logic target_clear,
  input wire logic scl_out,
  input wire logic sda_change_en,
  input wire logic addressed_as_target_flag
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_ready: assert property (hreadyout) else $error("wait state seen");
  a_resp_okay: assert property (!hresp) else $error("error response seen");
  a_flag_cause: assert property ($rose(addressed_as_target_flag) |-> $past(addr_valid))
    else $error("flag set without a call");
  a_flag_sticky: assert property (addressed_as_target_flag && !target_clear |=> addressed_as_target_flag)
    else $error("flag dropped by itself");
  a_flag_clear: assert property (target_clear && !addr_valid |=> !addressed_as_target_flag)
    else $error("flag not cleared");
  a_hold_pulse: assert property (sda_change_en |=> !sda_change_en) else $error("change pulse too long");
  a_change_low: assert property (sda_change_en && scl_run && $past(scl_run) |-> !scl_out)
    else $error("data change outside low phase");
  a_scl_idle: assert property (!scl_run ##1 !scl_run |-> scl_out) else $error("clock not idle high");
  // Shortest bit period is 20 cycles, so no phase is under 10; the checks below require at least 9
  a_low_min: assert property ($fell(scl_out) |=> (!scl_out || !scl_run)[*8]) else $error("low too short");
  a_high_min: assert property ($rose(scl_out) && scl_run |=> (scl_out || !scl_run)[*8])
    else $error("high too short");
  c_match: cover property ($rose(addressed_as_target_flag));
  c_change: cover property (sda_change_en);
  c_fall: cover property ($fell(scl_out));
endmodule
`default_nettype wire

// ===== tb/ibr_peer_model.sv
// Model of the byte engine facing the block: calling addresses and data-line requests
`timescale 1ns/1ps
`default_nettype none
module ibr_peer_model (
  // Clock
  input wire logic hclk,
  // Towards the block
  output logic addr_valid,
  output logic [6:0] call_addr,
  output logic target_clear,
  output logic sda_change_req
);
  initial begin
    addr_valid = 1'b0;
    call_addr = 7'h00;
    target_clear = 1'b0;
    sda_change_req = 1'b1;
  end
  // One-cycle strobe; the address is turned over afterwards so a stale match cannot hide
  task automatic call(input logic [6:0] a, input logic c);
    addr_valid <= 1'b1;
    call_addr <= a;
    target_clear <= c;
    @(posedge hclk);
    addr_valid <= 1'b0;
    target_clear <= 1'b0;
    call_addr <= ~a;
  endtask
  // Clear strobe alone, with no calling address beside it
  task automatic clr();
    target_clear <= 1'b1;
    @(posedge hclk);
    target_clear <= 1'b0;
  endtask
  task automatic req(input logic r);
    sda_change_req <= r;
  endtask
endmodule
`default_nettype wire

// ===== tb/ibr_top_bench.sv
// Bench: registers, address match and serial clock timing
`timescale 1ns/1ps
`default_nettype none
module ibr_top_bench;
  import ibr_pkg::*;
  logic hclk, hresetn, hsel, hwrite, scl_run, hreadyout, hresp, scl_out, sda_change_en;
  logic addressed_as_target_flag, addr_valid, target_clear, sda_change_req;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [6:0] call_addr;
  int err_total = 0, tests_run = 0, cycles = 0, lo, hi, hd;
  // Register value, bit period, hold count; 8'h0b and 8'h40 give one rate with two holds
  logic [7:0] rate_v [6] = '{8'h0b, 8'h40, 8'h80, 8'h87, 8'h0f, 8'h3f};
  int per_v [6] = '{40, 40, 80, 160, 68, 3840};
  int hold_v [6] = '{9, 7, 7, 10, 13, 513};
  ibr_top ibr_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .scl_run(scl_run), .addr_valid(addr_valid),
    .call_addr(call_addr), .target_clear(target_clear), .sda_change_req(sda_change_req),
    .scl_out(scl_out), .sda_change_en(sda_change_en), .addressed_as_target_flag(addressed_as_target_flag));
  ibr_peer_model ibr_peer_model_i (.hclk(hclk), .addr_valid(addr_valid), .call_addr(call_addr),
    .target_clear(target_clear), .sda_change_req(sda_change_req));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (err_total == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Counts one low and one high phase and the hold delay from the fall
  task automatic meas();
    lo = 0;
    hi = 0;
    hd = 0;
    do @(negedge hclk); while (scl_out !== 1'b1);
    do @(negedge hclk); while (scl_out !== 1'b0);
    while (scl_out === 1'b0) begin
      lo++;
      if (sda_change_en === 1'b1) hd = lo - 1;
      @(negedge hclk);
    end
    while (scl_out === 1'b1) begin
      hi++;
      @(negedge hclk);
    end
    @(posedge hclk);
  endtask
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, scl_run, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, ADDR_TARGET_ID, 32'h0);
    chk(rd, {24'h0, RST_TARGET_ID});
    xfer(1'b0, ADDR_BIT_RATE, 32'h0);
    chk(rd, {24'h0, RST_BIT_RATE});
    xfer(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, scl_out}, 32'h1);
    xfer(1'b1, ADDR_TARGET_ID, 32'h5a);
    xfer(1'b0, ADDR_TARGET_ID, 32'h0);
    chk(rd, 32'h5a);
    ibr_peer_model_i.call(7'h2d, 1'b1);
    @(negedge hclk);
    chk({31'h0, addressed_as_target_flag}, 32'h1);
    @(posedge hclk);
    xfer(1'b1, ADDR_STATUS, 32'h0);
    xfer(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h3);
    ibr_peer_model_i.call(7'h2c, 1'b1);
    @(negedge hclk);
    chk({31'h0, addressed_as_target_flag}, 32'h0);
    @(posedge hclk);
    ibr_peer_model_i.call(7'h2d, 1'b0);
    @(negedge hclk);
    chk({31'h0, addressed_as_target_flag}, 32'h1);
    @(posedge hclk);
    ibr_peer_model_i.call(7'h2c, 1'b0);
    @(negedge hclk);
    chk({31'h0, addressed_as_target_flag}, 32'h1);
    @(posedge hclk);
    ibr_peer_model_i.clr();
    @(negedge hclk);
    chk({31'h0, addressed_as_target_flag}, 32'h0);
    @(posedge hclk);
    for (int i = 0; i < 6; i++) begin
      scl_run <= 1'b0;
      // A hold still pending from the last fall must run out before the clock restarts
      repeat (600) @(posedge hclk);
      xfer(1'b1, ADDR_BIT_RATE, {24'h0, rate_v[i]});
      xfer(1'b0, ADDR_BIT_RATE, 32'h0);
      chk(rd, {24'h0, rate_v[i]});
      scl_run <= 1'b1;
      meas();
      chk(lo, per_v[i] / 2);
      chk(hi, per_v[i] - per_v[i] / 2);
      chk(hd, hold_v[i]);
    end
    ibr_peer_model_i.req(1'b0);
    meas();
    chk(hd, 0);
    summarize();
  end
endmodule
bind ibr_top ibr_props ibr_props_i (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .scl_run(scl_run), .addr_valid(addr_valid), .target_clear(target_clear), .scl_out(scl_out),
  .sda_change_en(sda_change_en), .addressed_as_target_flag(addressed_as_target_flag));
`default_nettype wire
